// [design/stp_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// Memory-side test port: instruction decode, data register selection, capture.
module stp_dev (
    input wire logic core_clk,
    input wire logic rst,
    stp_link_if.dev link,
    input wire logic [stp_pkg::BSR_W-1:0] pin_levels,
    output logic out_float,
    output logic [2:0] active_ins
);
    import stp_pkg::*;

    // Data register that an instruction places between TDI and TDO.
    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_IDENT = 2'h1,
        SEL_BOUNDARY = 2'h2
    } stp_sel_type;

    // Whole port state, registered in one place.
    typedef struct packed {
        stp_state_type st;
        logic [IR_W-1:0] ir_shift;
        logic [IR_W-1:0] ir;
        logic [ID_W-1:0] id_shift;
        logic [BSR_W-1:0] bsr;
        logic byp;
        logic [2:0] tms_run;
        logic tdo;
        logic tdo_oe;
        logic flt;
    } stp_dev_type;
    stp_dev_type r_reg;
    stp_dev_type r_next;

    // Filtered link inputs and the decoded register select.
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    stp_sel_type sel;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    // Maps an instruction code to the data register that it selects.
    function automatic stp_sel_type stp_decode(input logic [IR_W-1:0] code);
        stp_sel_type s;
        s = SEL_BYPASS;
        unique case (code)
            INS_EXT: s = SEL_BOUNDARY;
            INS_IDENT: s = SEL_IDENT;
            INS_FLOAT: s = SEL_BOUNDARY;
            INS_SAMPLE: s = SEL_BOUNDARY;
            INS_BYPASS: s = SEL_BYPASS;
            // The three reserved codes have no function and fall back to bypass.
            default: s = SEL_BYPASS;
        endcase
        return s;
    endfunction

    // Decodes the active instruction once for the whole port.
    assign sel = stp_decode(r_reg.ir);

    // ------------------------------------------------------------
    // Link input synchronisers
    // ------------------------------------------------------------
    // The test clock comes from another domain, so only its filtered edges are used.
    stp_sync u_tck (
        .core_clk(core_clk),
        .rst(rst),
        .din(link.tck),
        .dout(),
        .rise(tck_rise),
        .fall(tck_fall)
    );

    // Mode select is read only at a filtered test clock rise.
    stp_sync u_tms (
        .core_clk(core_clk),
        .rst(rst),
        .din(link.tms),
        .dout(tms_s),
        .rise(),
        .fall()
    );

    // Serial input shares the latency of the clock path, so it is settled when used.
    stp_sync u_tdi (
        .core_clk(core_clk),
        .rst(rst),
        .din(link.tdi),
        .dout(tdi_s),
        .rise(),
        .fall()
    );

    // ------------------------------------------------------------
    // Controller and data registers
    // ------------------------------------------------------------
    // Acts on the filtered rising edge of the test clock, drives TDO on the falling.
    always_comb begin
        logic serial;
        serial = 1'b1;
        r_next = r_reg;
        if (tck_rise) begin
            r_next.st = stp_step(r_reg.st, tms_s);
            // Counts rises with mode select high, so five always reach reset.
            if (!tms_s) begin
                r_next.tms_run = 3'h0;
            end else if (r_reg.tms_run == 3'(RESET_TMS_COUNT - 1)) begin
                // The counter saturates here and holds the port in reset.
                r_next.st = ST_RESET;
            end else begin
                r_next.tms_run = r_reg.tms_run + 3'h1;
            end
            unique case (r_reg.st)
                ST_CAP_IR: begin
                    // The fixed low pattern lets a board test find a broken chain.
                    r_next.ir_shift = {1'b0, IR_CAPTURE_LOW};
                end
                ST_SHIFT_IR: begin
                    // Each rise moves the instruction word one place towards TDO.
                    r_next.ir_shift = {tdi_s, r_reg.ir_shift[IR_W-1:1]};
                end
                ST_UPD_IR: begin
                    // Only here does a shifted code become the active instruction.
                    r_next.ir = r_reg.ir_shift;
                    r_next.flt = (r_reg.ir_shift == INS_FLOAT);
                end
                ST_CAP_DR: begin
                    // Capture loads the selected register; the pins are only ever read.
                    unique case (sel)
                        SEL_IDENT: r_next.id_shift = ID_WORD;
                        SEL_BOUNDARY: r_next.bsr = pin_levels;
                        default: r_next.byp = 1'b0;
                    endcase
                end
                ST_SHIFT_DR: begin
                    unique case (sel)
                        SEL_IDENT: begin
                            // The identification word leaves its bit 0 first.
                            r_next.id_shift = {tdi_s, r_reg.id_shift[ID_W-1:1]};
                        end
                        SEL_BOUNDARY: begin
                            // The boundary word enters at its top bit and leaves at bit 0.
                            r_next.bsr = {tdi_s, r_reg.bsr[BSR_W-1:1]};
                        end
                        default: r_next.byp = tdi_s;
                    endcase
                end
                ST_UPD_DR: begin
                    // No preload exists, so update leaves the boundary word and pins alone.
                    r_next.bsr = r_reg.bsr;
                end
                default: begin
                    // Other states leave the data registers as they are.
                    r_next.bsr = r_reg.bsr;
                end
            endcase
            // Entering the reset state restores identification and normal drive at once.
            if (r_next.st == ST_RESET) begin
                r_next.ir = INS_IDENT;
                r_next.flt = 1'b0;
            end
        end
        // Serial data selected by state and instruction; reserved codes use bypass.
        if (r_reg.st == ST_SHIFT_IR) begin
            serial = r_reg.ir_shift[0];
        end else begin
            unique case (sel)
                SEL_IDENT: serial = r_reg.id_shift[0];
                SEL_BOUNDARY: serial = r_reg.bsr[0];
                default: serial = r_reg.byp;
            endcase
        end
        // TDO moves only after a falling edge, a full test clock before the controller reads it at its next falling edge.
        if (tck_fall) begin
            r_next.tdo = serial;
            r_next.tdo_oe = (r_reg.st == ST_SHIFT_IR) || (r_reg.st == ST_SHIFT_DR);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Registers the whole port state; reset gives the identification instruction.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= ST_RESET;
            r_reg.ir <= INS_IDENT;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output is a register copy, so nothing combinational leaves the port.
    assign link.tdo = r_reg.tdo;
    assign link.tdo_oe = r_reg.tdo_oe;
    assign out_float = r_reg.flt;
    assign active_ins = r_reg.ir;
endmodule
`default_nettype wire

// [design/stp_pkg.sv]
`default_nettype none
package stp_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 69;
    localparam logic [2:0] INS_EXT = 3'h0;
    localparam logic [2:0] INS_IDENT = 3'h1;
    localparam logic [2:0] INS_FLOAT = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    // Identification word; the upper bits are arbitrary, bit 0 marks presence.
    localparam logic [31:0] ID_WORD = 32'h0000_2001;
    localparam int RESET_TMS_COUNT = 5;
    // Test clock period and the divider count on the core clock (125 MHz).
    localparam int CORE_PERIOD_PS = 8000;
    localparam int TEST_PERIOD_MIN_NS = 100;
    localparam int TCK_HALF_CYCLES = (TEST_PERIOD_MIN_NS * 1000 + 2 * CORE_PERIOD_PS - 1)
        / (2 * CORE_PERIOD_PS);
    // Test port controller states, Gray coded along the shift paths.
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
        ST_SHIFT_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PAUSE_DR = 4'h5, ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC, ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SHIFT_IR = 4'hE,
        ST_EX1_IR = 4'hA, ST_PAUSE_IR = 4'hB, ST_EX2_IR = 4'h9, ST_UPD_IR = 4'h8
    } stp_state_type;
    // Next controller state from the current state and TMS.
    function automatic stp_state_type stp_step(input stp_state_type s, input logic tms);
        stp_state_type n;
        n = ST_RESET;
        unique case (s)
            ST_RESET: n = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = tms ? ST_EX1_DR : ST_SHIFT_DR;
            ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = tms ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = tms ? ST_EX1_IR : ST_SHIFT_IR;
            ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = tms ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
        endcase
        return n;
    endfunction
endpackage
`default_nettype wire

// [design/stp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Serial test link between the board controller and the memory test port.
interface stp_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface
`default_nettype wire

// [design/stp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree.
module stp_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic [2:0] pipe;
        logic level;
        logic rise;
        logic fall;
    } stp_sync_type;
    stp_sync_type s_reg;
    stp_sync_type s_next;

    // Stage one feeds only stage two; the filtered level updates on agreement.
    always_comb begin
        s_next = s_reg;
        s_next.pipe = {s_reg.pipe[1:0], din};
        s_next.rise = 1'b0;
        s_next.fall = 1'b0;
        if (s_reg.pipe[1] == s_reg.pipe[2] && s_reg.pipe[2] != s_reg.level) begin
            s_next.level = s_reg.pipe[2];
            s_next.rise = s_reg.pipe[2];
            s_next.fall = ~s_reg.pipe[2];
        end
    end

    // Registers the synchroniser state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.level;
    assign rise = s_reg.rise;
    assign fall = s_reg.fall;
endmodule
`default_nettype wire

// [design/stp_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
// Board-side controller: runs one TMS/TDI bit per generated test clock cycle.
module stp_ctl (
    input wire logic core_clk,
    input wire logic rst,
    stp_link_if.ctl link,
    input wire logic bit_valid,
    input wire logic bit_tms,
    input wire logic bit_tdi,
    output logic bit_ready,
    output logic tdo_valid,
    output logic tdo_bit
);
    import stp_pkg::*;

    typedef struct packed {
        logic [7:0] div;
        logic tck;
        logic busy;
        logic tms;
        logic tdi;
        logic ready;
        logic tv;
        logic tb;
    } stp_ctl_type;
    stp_ctl_type c_reg;
    stp_ctl_type c_next;
    logic tdo_s;
    logic tdo_oe_s;

    stp_sync u_tdo (.core_clk(core_clk), .rst(rst), .din(link.tdo), .dout(tdo_s),
        .rise(), .fall());
    // The output enable takes the same path, so both arrive together.
    stp_sync u_tdo_oe (.core_clk(core_clk), .rst(rst), .din(link.tdo_oe), .dout(tdo_oe_s),
        .rise(), .fall());

    // Test clock from a divider never faster than 10 MHz; caller must avoid reserved codes.
    always_comb begin
        c_next = c_reg;
        c_next.tv = 1'b0;
        c_next.ready = 1'b0;
        if (!c_reg.busy) begin
            c_next.ready = 1'b1;
            if (bit_valid && c_reg.ready) begin
                c_next.busy = 1'b1;
                c_next.ready = 1'b0;
                c_next.tms = bit_tms;
                c_next.tdi = bit_tdi;
                c_next.div = '0;
            end
        end else if (c_reg.div == 8'(TCK_HALF_CYCLES - 1)) begin
            c_next.div = '0;
            c_next.tck = ~c_reg.tck;
            if (c_reg.tck) begin
                c_next.busy = 1'b0;
                c_next.tv = 1'b1;
                c_next.tb = tdo_oe_s ? tdo_s : 1'b1; // A released line reads as one.
            end
        end else begin
            c_next.div = c_reg.div + 8'h01;
        end
    end

    // Registers the controller state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            c_reg <= '0;
            c_reg.tms <= 1'b1;
            c_reg.tdi <= 1'b1;
        end else begin
            c_reg <= c_next;
        end
    end

    assign link.tck = c_reg.tck;
    assign link.tms = c_reg.tms;
    assign link.tdi = c_reg.tdi;
    assign bit_ready = c_reg.ready;
    assign tdo_valid = c_reg.tv;
    assign tdo_bit = c_reg.tb;
endmodule
`default_nettype wire

// [bench/stp_link_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Link checker
// ----------------------------------------
module stp_link_checker
    import stp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic tck_reg;
    logic first_ir_reg;
    stp_state_type st_reg;
    // Follows the controller state on each sampled test clock rise.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tck_reg <= 1'b0;
            first_ir_reg <= 1'b0;
            st_reg <= ST_RESET;
        end else begin
            tck_reg <= tck;
            if (tck && !tck_reg) begin
                st_reg <= stp_step(st_reg, tms);
                first_ir_reg <= (st_reg == ST_CAP_IR) && !tms;
            end
        end
    end
    sequence in_shift;
        (st_reg == ST_SHIFT_DR || st_reg == ST_SHIFT_IR) [*8];
    endsequence
    sequence out_shift;
        (st_reg != ST_SHIFT_DR && st_reg != ST_SHIFT_IR) [*8];
    endsequence
    a_tck_high_time: assert property ($rose(tck) |=> tck [*6] ##1 !tck)
        else $error("test clock high phase has wrong length");
    a_tck_low_time: assert property ($fell(tck) |=> !tck [*6])
        else $error("test clock low phase too short");
    a_tms_hold: assert property (tck && $past(tck) |-> $stable(tms))
        else $error("mode select moved while test clock high");
    a_tdi_hold: assert property (tck && $past(tck) |-> $stable(tdi))
        else $error("serial input moved while test clock high");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("serial output moved while test clock high");
    a_oe_in_shift: assert property (in_shift |-> ##[0:8] tdo_oe)
        else $error("serial output not enabled in a shift state");
    a_oe_off_idle: assert property (out_shift |-> ##8 !tdo_oe)
        else $error("serial output enabled outside shift states");
    a_ir_capture_bit: assert property ($fell(tck) && first_ir_reg |-> ##6 tdo)
        else $error("first instruction bit out is not one");
endmodule
`default_nettype wire

// [bench/sram_tap_instruction_set_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_tap_instruction_set_tb;
    import stp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic bit_valid = 1'b0;
    logic bit_tms = 1'b1;
    logic bit_tdi = 1'b1;
    logic bit_ready;
    logic tdo_valid;
    logic tdo_bit;
    logic out_float;
    logic b;
    logic [2:0] active_ins;
    logic [BSR_W-1:0] pins = 69'h1_5A5A_C3C3_9669_0FF0;
    logic [BSR_W-1:0] got;
    logic [BSR_W-1:0] exp_v;
    logic [2:0] codes [5] = '{INS_EXT, INS_FLOAT, INS_SAMPLE, INS_BYPASS, INS_IDENT};
    int n_bits;
    int miscompares = 0;
    int checks = 0;
    stp_link_if lnk();
    stp_dev u_stp_dev(.core_clk(core_clk), .rst(rst), .link(lnk), .pin_levels(pins),
        .out_float(out_float), .active_ins(active_ins));
    stp_ctl u_stp_ctl(.core_clk(core_clk), .rst(rst), .link(lnk), .bit_valid(bit_valid),
        .bit_tms(bit_tms), .bit_tdi(bit_tdi), .bit_ready(bit_ready),
        .tdo_valid(tdo_valid), .tdo_bit(tdo_bit));
    stp_link_checker u_stp_link_checker(.core_clk(core_clk), .rst(rst), .tck(lnk.tck),
        .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe(lnk.tdo_oe));
    // Core clock, 8 ns period.
    always #4 core_clk = ~core_clk;
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Compares one value with its expectation.
    task automatic chk(input logic [BSR_W-1:0] seen, input logic [BSR_W-1:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask
    // Runs one test clock cycle through the controller and returns the output bit.
    task automatic go(input logic tms, input logic tdi, output logic tdo);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (bit_ready !== 1'b1 && n < 100);
        if (bit_ready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        bit_valid = 1'b1;
        bit_tms = tms;
        bit_tdi = tdi;
        @(negedge core_clk);
        bit_valid = 1'b0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tdo_valid !== 1'b1 && n < 200);
        if (tdo_valid !== 1'b1) begin
            miscompares++;
            test_done();
        end
        tdo = tdo_bit;
    endtask
    // Shifts n bits from a shift state, then passes update and returns to idle.
    task automatic shift(input int n, input logic [BSR_W-1:0] din,
        output logic [BSR_W-1:0] dout);
        logic t;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            go(i == n - 1, din[i], t);
            dout[i] = t;
        end
        go(1'b1, 1'b0, t);
        go(1'b0, 1'b0, t);
    endtask
    // Loads an instruction from idle and checks the captured low bits.
    task automatic ir_load(input logic [2:0] code);
        go(1'b1, 1'b0, b);
        go(1'b1, 1'b0, b);
        go(1'b0, 1'b0, b);
        go(1'b0, 1'b0, b);
        shift(IR_W, {66'h0, code}, got);
        chk({67'h0, got[1:0]}, {67'h0, IR_CAPTURE_LOW});
    endtask
    // Captures and shifts the selected data register from idle.
    task automatic dr_scan(input int n, input logic [BSR_W-1:0] din);
        go(1'b1, 1'b0, b);
        go(1'b0, 1'b0, b);
        go(1'b0, 1'b0, b);
        shift(n, din, got);
    endtask
    // Main sequence: reset, identification, every defined code, port reset.
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk({66'h0, active_ins}, {66'h0, INS_IDENT});
        go(1'b0, 1'b0, b);
        dr_scan(ID_W, '1);
        chk(got, {37'h0, ID_WORD});
        $display("test identify done");
        for (int k = 0; k < 5; k++) begin
            ir_load(codes[k]);
            chk({66'h0, active_ins}, {66'h0, codes[k]});
            for (int j = 0; j < 2; j++) begin
                pins = {pins[BSR_W-2:0], ~pins[BSR_W-1]};
                exp_v = pins;
                n_bits = BSR_W;
                if (codes[k] == INS_BYPASS) begin
                    n_bits = 8;
                    exp_v = {61'h0, ~pins[6:0], 1'b0};
                end else if (codes[k] == INS_IDENT) begin
                    n_bits = ID_W;
                    exp_v = {37'h0, ID_WORD};
                end
                dr_scan(n_bits, ~pins);
                chk(got, exp_v);
                chk({68'h0, out_float}, {68'h0, codes[k] == INS_FLOAT});
            end
            $display("test code %0h done", codes[k]);
        end
        ir_load(INS_FLOAT);
        repeat (5) go(1'b1, 1'b0, b);
        chk({66'h0, active_ins}, {66'h0, INS_IDENT});
        chk({68'h0, out_float}, 69'h0);
        $display("test port reset done");
        test_done();
    end
endmodule
`default_nettype wire
